// [rtl/i2c_addr_match.sv]
// Slave address recognition for a two-wire serial bus, with Wishbone registers.
// Assumes scl_i and sda_i come from pins and the bus master runs on clk_i.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps

// Function
// R01: Own slave address sits in config bits 10:1 and selects this slave.
// R02: Seven-bit addressing compares only own address bits 6:0.
// R03: Ten-bit enable set means all own address bits 9:0 are compared.
// R04: Config bit 15 turns ten-bit address recognition off or on.
// R05: A match sets the address match flag and records read or write.
// R06: Config bits 26:17 act as second address, mask or range low limit.
// R07: All-zero address byte with write direction is the general call.
// R08: General call is acknowledged only while its enable bit is one.
module i2c_addr_match (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [i2c_match_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Interrupt
    output logic irq_o,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Compares the cared-for bits of an address against own and second value
    function automatic logic addr_hit(input logic [9:0] a, input logic [9:0] own,
                                      input logic [9:0] sec, input i2c_match_pkg::mode_t mode,
                                      input logic [9:0] care);
        logic hit;
        hit = 1'b0;
        case (mode)
            i2c_match_pkg::MODE_MASK: hit = (((a ^ own) & ~sec & care) == 10'h000);
            i2c_match_pkg::MODE_TWO: hit = (((a ^ own) & care) == 10'h000) ||
                                           (((a ^ sec) & care) == 10'h000);
            i2c_match_pkg::MODE_RANGE: hit = ((a & care) >= (sec & care)) && ((a & care) <= (own & care));
            default: hit = (((a ^ own) & care) == 10'h000);
        endcase
        return hit;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR2,
        S_ACK,
        S_WAIT
    } state_t;

    i2c_match_pkg::addr_cfg_t cfg_r;
    i2c_match_pkg::ctrl_t ctrl_r;
    logic [i2c_match_pkg::IRQ_W-1:0] int_status_r;
    logic [i2c_match_pkg::IRQ_W-1:0] int_status_nxt;
    logic [i2c_match_pkg::IRQ_W-1:0] int_enable_r;
    logic [i2c_match_pkg::IRQ_W-1:0] int_clear;
    logic [i2c_match_pkg::IRQ_W-1:0] events;
    logic [31:0] rd_data;
    logic wb_req;
    logic wb_wr;
    logic ack_r;
    logic [31:0] dat_r;
    logic irq_r;
    logic sda_drv_r;
    logic sda_oe_r;

    logic [1:0] line_q;
    logic [1:0] line_prev;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    state_t state_r;
    state_t after_ack_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] byte_now;
    logic [1:0] upper_r;
    logic ten_sel_r;
    logic ack_on_r;
    logic dir_r;
    logic busy_r;
    logic match_evt;
    logic stop_evt;

    logic gc_hit;
    logic hdr_ok;
    logic hdr_rd_ok;
    logic hit7;
    logic hit10;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    line_sync #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({scl_i, sda_i}),
        .q_o(line_q),
        .prev_o(line_prev)
    );

    assign scl_s = line_q[1];
    assign sda_s = line_q[0];
    assign scl_rise = scl_s & ~line_prev[1];
    assign scl_fall = ~scl_s & line_prev[1];
    assign start_det = scl_s & line_prev[1] & ~sda_s & line_prev[0];
    assign stop_det = scl_s & line_prev[1] & sda_s & ~line_prev[0];

    // ************************************************************
    // Address decision
    // ************************************************************
    assign byte_now = {shift_r[6:0], sda_s};
    // Direction bit included: only a write to address zero is a call
    assign gc_hit = cfg_r.general_call_enable && (byte_now == i2c_match_pkg::GC_BYTE); // R07 R08
    assign hdr_ok = (byte_now[7:3] == i2c_match_pkg::HDR_PREFIX) &&
                    addr_hit({byte_now[2:1], 8'h00}, cfg_r.own_address, cfg_r.second_address_value,
                             ctrl_r.address_mode_select, i2c_match_pkg::CARE_HDR); // R06
    assign hdr_rd_ok = hdr_ok && byte_now[0] && ten_sel_r && (byte_now[2:1] == upper_r);
    assign hit7 = addr_hit({3'h0, byte_now[7:1]}, cfg_r.own_address, cfg_r.second_address_value,
                           ctrl_r.address_mode_select, i2c_match_pkg::CARE_7); // R01 R02 R06
    assign hit10 = addr_hit({upper_r, byte_now}, cfg_r.own_address, cfg_r.second_address_value,
                            ctrl_r.address_mode_select, i2c_match_pkg::CARE_10); // R01 R03 R06

    // ************************************************************
    // Bus phase sequencer
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !ctrl_r.enable)
        begin
            state_r <= S_IDLE;
            after_ack_r <= S_WAIT;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            upper_r <= 2'h0;
            ten_sel_r <= 1'b0;
            ack_on_r <= 1'b0;
            sda_oe_r <= 1'b0;
            dir_r <= 1'b0;
            busy_r <= 1'b0;
            match_evt <= 1'b0;
            stop_evt <= 1'b0;
        end
        else
        begin
            match_evt <= 1'b0;
            stop_evt <= 1'b0;
            if (stop_det)
            begin
                state_r <= S_IDLE;
                ten_sel_r <= 1'b0;
                ack_on_r <= 1'b0;
                sda_oe_r <= 1'b0;
                busy_r <= 1'b0;
                stop_evt <= 1'b1;
            end
            else if (start_det)
            begin
                state_r <= S_ADDR;
                bit_cnt_r <= 3'h0;
                ack_on_r <= 1'b0;
                sda_oe_r <= 1'b0;
                busy_r <= 1'b1;
            end
            else
            begin
                case (state_r)
                    S_ADDR, S_ADDR2:
                    begin
                        if (scl_rise)
                        begin
                            shift_r <= byte_now;
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == i2c_match_pkg::BIT_LAST)
                            begin
                                state_r <= S_WAIT;
                                if (state_r == S_ADDR2)
                                begin
                                    if (hit10)
                                    begin
                                        ten_sel_r <= 1'b1;
                                        match_evt <= 1'b1; // R05
                                        dir_r <= 1'b0;
                                        after_ack_r <= S_WAIT;
                                        state_r <= S_ACK;
                                    end
                                end
                                else if (gc_hit)
                                begin
                                    match_evt <= 1'b1; // R05 R07
                                    dir_r <= 1'b0;
                                    after_ack_r <= S_WAIT;
                                    state_r <= S_ACK;
                                end
                                else if (cfg_r.ten_bit_enable) // R04
                                begin
                                    if (hdr_rd_ok)
                                    begin
                                        match_evt <= 1'b1; // R05
                                        dir_r <= 1'b1;
                                        after_ack_r <= S_WAIT;
                                        state_r <= S_ACK;
                                    end
                                    else if (hdr_ok && !byte_now[0])
                                    begin
                                        upper_r <= byte_now[2:1];
                                        ten_sel_r <= 1'b0;
                                        after_ack_r <= S_ADDR2;
                                        state_r <= S_ACK;
                                    end
                                end
                                else if (hit7)
                                begin
                                    match_evt <= 1'b1; // R05
                                    dir_r <= byte_now[0];
                                    after_ack_r <= S_WAIT;
                                    state_r <= S_ACK;
                                end
                            end
                        end
                    end
                    S_ACK:
                    begin
                        // Pull data low for the ninth clock
                        if (scl_fall)
                        begin
                            if (!ack_on_r)
                            begin
                                ack_on_r <= 1'b1;
                                sda_oe_r <= 1'b1;
                            end
                            else
                            begin
                                ack_on_r <= 1'b0;
                                sda_oe_r <= 1'b0;
                                bit_cnt_r <= 3'h0;
                                state_r <= after_ack_r;
                            end
                        end
                    end
                    S_IDLE, S_WAIT:
                    begin
                        sda_oe_r <= 1'b0;
                    end
                    default:
                    begin
                        state_r <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Open-drain line only ever pulled low
    always_ff @(posedge clk_i)
    begin
        sda_drv_r <= 1'b0;
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************
    assign events = {stop_evt, match_evt};
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wb_wr = wb_req && wb_we_i;
    assign int_clear = (wb_wr && (wb_adr_i == i2c_match_pkg::OFS_INT_CLEAR)) ?
                       wb_dat_i[i2c_match_pkg::IRQ_W-1:0] & {i2c_match_pkg::IRQ_W{wb_sel_i[0]}} :
                       {i2c_match_pkg::IRQ_W{1'b0}};
    // Set wins over a clear in the same cycle
    assign int_status_nxt = (int_status_r & ~int_clear) | events;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            int_status_r <= i2c_match_pkg::IRQ_RESET;
            irq_r <= 1'b0;
        end
        else
        begin
            int_status_r <= int_status_nxt; // R05
            irq_r <= |(int_status_nxt & int_enable_r);
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_r <= i2c_match_pkg::addr_cfg_t'(i2c_match_pkg::ADDR_CFG_RESET);
            ctrl_r <= i2c_match_pkg::ctrl_t'(i2c_match_pkg::CTRL_RESET);
            int_enable_r <= i2c_match_pkg::IRQ_RESET;
        end
        else if (wb_wr)
        begin
            case (wb_adr_i)
                i2c_match_pkg::OFS_ADDR_CFG:
                begin
                    cfg_r <= i2c_match_pkg::addr_cfg_t'(merge_sel(cfg_r, wb_dat_i, wb_sel_i) &
                                                       i2c_match_pkg::ADDR_CFG_MASK);
                end
                i2c_match_pkg::OFS_CTRL:
                begin
                    ctrl_r <= i2c_match_pkg::ctrl_t'(merge_sel(ctrl_r, wb_dat_i, wb_sel_i) &
                                                    i2c_match_pkg::CTRL_MASK);
                end
                i2c_match_pkg::OFS_INT_ENABLE:
                begin
                    if (wb_sel_i[0])
                    begin
                        int_enable_r <= wb_dat_i[i2c_match_pkg::IRQ_W-1:0];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // ************************************************************
    // Register reads and acknowledge
    // ************************************************************
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            i2c_match_pkg::OFS_ADDR_CFG: rd_data = cfg_r;
            i2c_match_pkg::OFS_CTRL: rd_data = ctrl_r;
            i2c_match_pkg::OFS_STATUS:
            begin
                rd_data[i2c_match_pkg::ST_DIR] = dir_r;
                rd_data[i2c_match_pkg::ST_BUSY] = busy_r;
                rd_data[i2c_match_pkg::ST_SEL] = (state_r == S_ACK);
            end
            i2c_match_pkg::OFS_INT_STATUS: rd_data[i2c_match_pkg::IRQ_W-1:0] = int_status_r;
            i2c_match_pkg::OFS_INT_ENABLE: rd_data[i2c_match_pkg::IRQ_W-1:0] = int_enable_r;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= wb_req;
            dat_r <= wb_req ? rd_data : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o = irq_r;
    assign sda_o = sda_drv_r;
    assign sda_oe_o = sda_oe_r;
endmodule

// [rtl/i2c_match_pkg.sv]
// Constants, register layouts and modes of the two-wire slave address matcher.
// Assumes a 32-bit register bus with byte addresses.
package i2c_match_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADR_W-1:0] OFS_INT_STATUS = 8'h08;
    localparam logic [ADR_W-1:0] OFS_INT_CLEAR = 8'h0c;
    localparam logic [ADR_W-1:0] OFS_INT_ENABLE = 8'h10;
    localparam logic [ADR_W-1:0] OFS_ADDR_CFG = 8'h24;

    // ************************************************************
    // Modes of the second address value
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_MASK = 2'h0,
        MODE_TWO = 2'h1,
        MODE_RANGE = 2'h2,
        MODE_OWN = 2'h3
    } mode_t;

    // ************************************************************
    // Register layouts
    // ************************************************************
    typedef struct packed {
        logic [4:0] rsv_hi;
        logic [9:0] second_address_value;
        logic rsv_16;
        logic ten_bit_enable;
        logic [3:0] rsv_mid;
        logic [9:0] own_address;
        logic general_call_enable;
    } addr_cfg_t;

    typedef struct packed {
        logic [28:0] rsv;
        mode_t address_mode_select;
        logic enable;
    } ctrl_t;

    localparam logic [31:0] ADDR_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_CFG_MASK = 32'h07fe_87ff;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0007;

    // Interrupt bit positions
    localparam int IRQ_W = 2;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_STOP = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // Status bit positions
    localparam int ST_DIR = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_SEL = 2;

    // ************************************************************
    // Address phase constants
    // ************************************************************
    localparam logic [9:0] CARE_7 = 10'h07f;
    localparam logic [9:0] CARE_HDR = 10'h300;
    localparam logic [9:0] CARE_10 = 10'h3ff;
    localparam logic [4:0] HDR_PREFIX = 5'h1e;
    localparam logic [7:0] GC_BYTE = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;

endpackage

// [rtl/line_sync.sv]
// Two-flop synchroniser with a third stage for edge finding.
// Assumes asynchronous inputs and a synchronous active-high reset.
`timescale 1ns/1ps

module line_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Lines
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] prev_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    logic [W-1:0] prev_r;

    // Idle bus lines are high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= '1;
            q_r <= '1;
            prev_r <= '1;
        end
        else
        begin
            meta_r <= d_i;
            q_r <= meta_r;
            prev_r <= q_r;
        end
    end

    assign q_o = q_r;
    assign prev_o = prev_r;
endmodule

// [bench/i2c_match_monitor.sv]
// Checker for the address matcher, bound to its top module ports.
// Assumes software writes whole words and the bus lines idle high.
`timescale 1ns/1ps

module i2c_match_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [i2c_match_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Interrupt and pins
    input wire logic irq_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    // ****************
    // Shadow state
    // ****************
    logic [1:0] s1, s2, s3;
    logic [3:0] n;
    logic [7:0] sh;
    logic got, ie, wr, rise, m7, hit;
    logic [31:0] cfg;
    logic [2:0] ctl;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign rise = s2[1] && !s3[1];
    assign m7 = got && ctl == 3'h7 && !cfg[15] && sh != 8'h00;
    assign hit = sh[7:1] == cfg[7:1];
    always_ff @(posedge clk_i)
    begin
        s1 <= rst_i ? 2'h3 : {scl_i, sda_i};
        s2 <= rst_i ? 2'h3 : s1;
        s3 <= rst_i ? 2'h3 : s2;
    end
    // First byte after a start
    always_ff @(posedge clk_i)
    begin
        got <= !rst_i && rise && n == 4'h7;
        if (rst_i || (s2 == 2'h2 && s3 == 2'h3)) n <= rst_i ? 4'hf : 4'h0;
        else if (rise && n != 4'hf) n <= n + 4'h1;
        if (rise) sh <= {sh[6:0], s2[0]};
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg <= 32'h0;
            ctl <= 3'h0;
            ie <= 1'b0;
        end
        else if (wr && wb_adr_i == 8'h24) cfg <= wb_dat_i;
        else if (wr && wb_adr_i == 8'h00) ctl <= wb_dat_i[2:0];
        else if (wr && wb_adr_i == 8'h10) ie <= wb_dat_i[0];
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence no_ack_s;
        !sda_oe_o [*8] ##1 !sda_oe_o [*8];
    endsequence
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_read_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    a_own_match: assert property (m7 && hit |-> ##[1:40] sda_oe_o)
        else $error("own address not acked");
    a_own_miss: assert property (m7 && !hit |=> no_ack_s)
        else $error("foreign address acked");
    a_gc_off: assert property (got && sh == 8'h00 && ctl == 3'h7 && !cfg[15] && !cfg[0] && cfg[7:1] != 7'h0
        |=> no_ack_s) else $error("general call acked while off");
    a_gc_on: assert property (got && sh == 8'h00 && cfg[0] && ctl[0] |-> ##[1:40] sda_oe_o)
        else $error("general call not acked");
    a_two_addr: assert property (got && ctl == 3'h3 && !cfg[15] && sh[7:1] == cfg[23:17]
        |-> ##[1:40] sda_oe_o) else $error("second address not acked");
    a_ten_head: assert property (got && ctl == 3'h7 && cfg[15] && sh == {5'h1e, cfg[10:9], 1'b0}
        |-> ##[1:40] sda_oe_o) else $error("ten bit header not acked");
    a_flag_irq: assert property (m7 && hit && ie |-> ##[1:8] irq_o)
        else $error("match flag did not interrupt");
endmodule

// [bench/i2c_master_model.sv]
// Bus master that addresses the slave, one SCL period of eight clocks.
// Assumes sda_i is the resolved open-drain line with a pull-up.
`timescale 1ns/1ps

module i2c_master_model (
    // Clock
    input wire logic clk_i,
    // Bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start();
        sda_low_o <= 1'b1;
        w(4);
        scl_o <= 1'b0;
        w(2);
    endtask
    // Eight bits MSB first, then the ninth clock for the answer
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low_o <= (i > 0) ? !b[i-1] : 1'b0;
            w(2);
            scl_o <= 1'b1;
            w(4);
            ack = !sda_i;
            scl_o <= 1'b0;
            w(2);
        end
    endtask
    task automatic stop();
        sda_low_o <= 1'b1;
        w(2);
        scl_o <= 1'b1;
        w(4);
        sda_low_o <= 1'b0;
        w(4);
    endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the address matcher: registers, interrupt, address phase.
// Assumes the master model and the checker are compiled before this file.
`timescale 1ns/1ps

module tb_top;
    logic clk_i, rst_i, we, cyc, stb, ack, irq, scl, sda_low, sda_oe, sda_do, sda;
    logic [7:0] adr;
    logic [31:0] dat, rdat, q;
    logic [3:0] sel;
    int mismatches = 0;
    int total_checks = 0;
    assign sda = !((sda_oe && !sda_do) || sda_low);
    i2c_addr_match DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_do), .sda_oe_o(sda_oe));
    i2c_master_model bm (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        adr <= a;
        we <= w;
        dat <= d;
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    function automatic logic [31:0] cf(input logic gc, input logic [9:0] own, input logic ten, input logic [9:0] s);
        return {5'h0, s, 1'b0, ten, 4'h0, own, gc};
    endfunction
    // One addressing frame; ten sends a second byte
    task automatic frame(input logic [31:0] c, input logic [1:0] m, input logic [7:0] b0, input logic [7:0] b1,
                         input logic e0, input logic e1, input logic ten);
        logic a;
        logic [31:0] r;
        logic f;
        f = ten ? e1 : e0;
        wr(8'h00, {29'h0, m, 1'b1});
        wr(8'h24, c);
        wr(8'h0c, 32'h3);
        bm.start();
        bm.put(b0, a);
        chk(a, e0);
        if (ten)
        begin
            bm.put(b1, a);
            chk(a, e1);
        end
        bm.stop();
        xfer(8'h08, 1'b0, 32'h0, r);
        chk(r[0], f);
        chk(r[1], 1'b1);
        xfer(8'h04, 1'b0, 32'h0, r);
        chk(r[2:1], 2'h0);
        chk(sda_do, 1'b0);
        if (f) chk(r[0], ten ? 1'b0 : b0[0]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ****************
    // Sequence
    // ****************
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        {rst_i, adr, dat, sel, we, cyc, stb} = {1'b1, 46'h0};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        xfer(8'h24, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        xfer(8'h40, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        wr(8'h24, 32'hffff_ffff);
        xfer(8'h24, 1'b0, 32'h0, q);
        chk(q, 32'h07fe_87ff);
        wr(8'h10, 32'h1);
        frame(cf(0, 10'h055, 0, 0), 2'h3, 8'hab, 8'h0, 1, 0, 0);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b1);
        wr(8'h10, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0);
        wr(8'h10, 32'h1);
        wr(8'h0c, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0);
        frame(cf(0, 10'h3d5, 0, 0), 2'h3, 8'haa, 8'h0, 1, 0, 0);
        frame(cf(0, 10'h055, 0, 0), 2'h3, 8'ha8, 8'h0, 0, 0, 0);
        frame(cf(0, 10'h055, 0, 0), 2'h3, 8'h00, 8'h0, 0, 0, 0);
        frame(cf(1, 10'h055, 0, 0), 2'h3, 8'h00, 8'h0, 1, 0, 0);
        frame(cf(0, 10'h055, 0, 10'h012), 2'h1, 8'h24, 8'h0, 1, 0, 0);
        frame(cf(0, 10'h054, 0, 10'h003), 2'h0, 8'hae, 8'h0, 1, 0, 0);
        frame(cf(0, 10'h054, 0, 10'h003), 2'h0, 8'hb0, 8'h0, 0, 0, 0);
        frame(cf(0, 10'h020, 0, 10'h010), 2'h2, 8'h31, 8'h0, 1, 0, 0);
        frame(cf(0, 10'h020, 0, 10'h010), 2'h2, 8'h42, 8'h0, 0, 0, 0);
        frame(cf(0, 10'h2a5, 1, 0), 2'h3, 8'hf4, 8'ha5, 1, 1, 1);
        frame(cf(0, 10'h2a5, 1, 0), 2'h3, 8'hf4, 8'ha4, 1, 0, 1);
        frame(cf(0, 10'h2a5, 0, 0), 2'h3, 8'h4a, 8'h0, 1, 0, 0);
        report_and_stop();
    end
endmodule

bind i2c_addr_match i2c_match_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o));
